// ---- logic/arm_defs.svh ----
// constants of the adc register map: selects, lengths, fields, reset values
`ifndef ARM_DEFS_SVH
`define ARM_DEFS_SVH
`define ARM_SEL_CMD_STAT 3'h0
`define ARM_SEL_MODE 3'h1
`define ARM_SEL_CFG 3'h2
`define ARM_SEL_DATA 3'h3
`define ARM_SEL_ID 3'h4
`define ARM_SEL_IO 3'h5
`define ARM_SEL_ZCAL 3'h6
`define ARM_SEL_GCAL 3'h7
`define ARM_LEN_BYTE 5'h08
`define ARM_LEN_HALF 5'h10
`define ARM_LEN_WORD 5'h18
`define ARM_CMD_LAST 5'h06
`define ARM_CMD_RW 6
`define ARM_CMD_SEL_HI 5
`define ARM_CMD_SEL_LO 3
`define ARM_STATUS_RST 8'h88
`define ARM_STAT_ZERO 2'h0
`define ARM_STAT_ONE 1'h1
`define ARM_MODE_RST 16'h000A
`define ARM_MODE_KEEP 16'hE0CF
`define ARM_MODE_OPM_HI 15
`define ARM_MODE_OPM_LO 13
`define ARM_DATA_TAIL 4'hF
`endif

// ---- logic/arm_pkg.sv ----
// types of the adc register map
package arm_pkg;
    // link phase, gray along wait-cmd-wdata; cmd to rdata flips both bits
    typedef enum logic [1:0] {
        PH_WAIT = 2'h0, PH_CMD = 2'h1, PH_WDATA = 2'h3, PH_RDATA = 2'h2
    } arm_phase_t;
    // read view, frozen while the link is in a frame
    typedef struct packed {
        logic [7:0] status;
        logic [15:0] mode;
        logic [15:0] cfg;
        logic [23:0] data;
        logic [7:0] id;
        logic [7:0] io;
        logic [23:0] zcal;
        logic [23:0] gcal;
    } arm_rdview_t;
    // events from the link, toggles with held payload
    typedef struct packed {
        logic wr_tgl;
        logic [2:0] wr_sel;
        logic [23:0] wr_word;
        logic rd_tgl;
        logic [2:0] rd_sel;
    } arm_lnk_ev_t;
    // conversion core report
    typedef struct packed {
        logic done;
        logic [19:0] result;
        logic clamped;
        logic [2:0] channel;
        logic pre_update;
    } arm_conv_t;
    // setup toward the conversion core
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] cfg;
        logic [7:0] io;
        logic [23:0] zcal;
        logic [23:0] gcal;
        logic filter_reset;
        logic conv_start;
    } arm_ctl_t;
    // link state
    typedef struct packed {
        arm_phase_t phase;
        logic busy;
        logic [4:0] cnt;
        logic [5:0] cmd;
        logic [2:0] sel;
        logic [23:0] sh;
        logic dout;
        logic rdy_s1;
        logic rdy_s2;
        arm_lnk_ev_t ev;
    } arm_lnk_st_t;
endpackage

// ---- logic/arm_link.sv ----
// serial link engine, clocked by the host's serial clock
`timescale 1ns/1ps
`include "arm_defs.svh"
module arm_link
    import arm_pkg::*;
(
    // link clock and reset
    input wire logic sclk,
    input wire logic nrst,
    // serial pins
    input wire logic din,
    output logic dout,
    // quasi-static view and ready level from the system side
    input wire arm_rdview_t rd_view,
    input wire logic rdy_lvl,
    // toward the system side
    output arm_lnk_ev_t ev,
    output logic busy
);
    arm_lnk_st_t st_r, st_nxt;
    logic [6:0] cmd_full; // command bits after the enable bit
    logic [23:0] rd_word; // selected word, left aligned
    logic [4:0] nbits; // length of the selected register
    assign dout = st_r.dout;
    assign ev = st_r.ev;
    assign busy = st_r.busy;
    // next state of the link
    always_comb begin
        st_nxt = st_r;
        cmd_full = {st_r.cmd, din};
        st_nxt.rdy_s1 = rdy_lvl;
        st_nxt.rdy_s2 = st_r.rdy_s1;
        unique case (cmd_full[`ARM_CMD_SEL_HI:`ARM_CMD_SEL_LO])
            `ARM_SEL_CMD_STAT: rd_word = {rd_view.status, 16'h0000};
            `ARM_SEL_MODE: rd_word = {rd_view.mode, 8'h00};
            `ARM_SEL_CFG: rd_word = {rd_view.cfg, 8'h00};
            `ARM_SEL_DATA: rd_word = rd_view.data;
            `ARM_SEL_ID: rd_word = {rd_view.id, 16'h0000};
            `ARM_SEL_IO: rd_word = {rd_view.io, 16'h0000};
            `ARM_SEL_ZCAL: rd_word = rd_view.zcal;
            `ARM_SEL_GCAL: rd_word = rd_view.gcal;
        endcase
        unique case (st_r.sel)
            `ARM_SEL_MODE, `ARM_SEL_CFG: nbits = `ARM_LEN_HALF;
            `ARM_SEL_DATA, `ARM_SEL_ZCAL, `ARM_SEL_GCAL: nbits = `ARM_LEN_WORD;
            `ARM_SEL_CMD_STAT, `ARM_SEL_ID, `ARM_SEL_IO: nbits = `ARM_LEN_BYTE;
        endcase
        unique case (st_r.phase)
            PH_WAIT: begin
                st_nxt.dout = st_r.rdy_s2; // idle pin mirrors ready
                if (!din) begin // ones hold us at the enable bit
                    st_nxt.phase = PH_CMD;
                    st_nxt.cnt = 5'h00;
                end
            end
            PH_CMD: begin
                st_nxt.cmd = cmd_full[5:0];
                st_nxt.cnt = st_r.cnt + 5'h01;
                if (st_r.cnt == `ARM_CMD_LAST) begin
                    st_nxt.sel = cmd_full[`ARM_CMD_SEL_HI:`ARM_CMD_SEL_LO];
                    st_nxt.sh = 24'h000000;
                    st_nxt.cnt = 5'h00;
                    if (cmd_full[`ARM_CMD_RW]) begin // read next
                        st_nxt.phase = PH_RDATA;
                        st_nxt.cnt = 5'h01;
                        st_nxt.dout = rd_word[23]; // msb first
                        st_nxt.sh = {rd_word[22:0], 1'b0};
                    end else if (cmd_full[`ARM_CMD_SEL_HI:`ARM_CMD_SEL_LO] ==
                                 `ARM_SEL_CMD_STAT) begin
                        st_nxt.phase = PH_WAIT; // command register rewritten
                    end else begin
                        st_nxt.phase = PH_WDATA; // write next
                    end
                end
            end
            PH_WDATA: begin
                st_nxt.sh = {st_r.sh[22:0], din}; // msb arrives first
                st_nxt.cnt = st_r.cnt + 5'h01;
                if (st_nxt.cnt == nbits) begin
                    st_nxt.ev.wr_word = {st_r.sh[22:0], din};
                    st_nxt.ev.wr_sel = st_r.sel;
                    st_nxt.ev.wr_tgl = ~st_r.ev.wr_tgl;
                    st_nxt.phase = PH_WAIT;
                end
            end
            PH_RDATA: begin
                if (st_r.cnt == nbits) begin
                    st_nxt.ev.rd_sel = st_r.sel;
                    st_nxt.ev.rd_tgl = ~st_r.ev.rd_tgl;
                    st_nxt.dout = st_r.rdy_s2;
                    st_nxt.phase = PH_WAIT;
                end else begin
                    st_nxt.dout = st_r.sh[23];
                    st_nxt.sh = {st_r.sh[22:0], 1'b0};
                    st_nxt.cnt = st_r.cnt + 5'h01;
                end
            end
        endcase
        st_nxt.busy = (st_nxt.phase != PH_WAIT);
    end
    // link registers; ready resets high so the pin idles not-ready
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.dout <= 1'b1;
            st_r.rdy_s1 <= 1'b1;
            st_r.rdy_s2 <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ---- logic/arm_top.sv ----
// register map and status logic of a sigma-delta adc with up to eight channels
`timescale 1ns/1ps
`include "arm_defs.svh"
module arm_top
    import arm_pkg::*;
#(
    // operating-mode code that means power-down
    parameter logic [2:0] PWRDN_MODE = 3'h3,
    // identification value, arbitrary
    parameter logic [7:0] PART_ID = 8'h5A
)(
    // system clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // serial link
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    // conversion core report
    input wire arm_conv_t conv,
    // setup toward the conversion core
    output arm_ctl_t ctl,
    // ready mirror, low while a fresh result waits
    output logic drdy_n
);

    // system-side state, one struct
    typedef struct packed {
        logic busy_s1;
        logic busy_s2;
        logic wr_s1;
        logic wr_s2;
        logic wr_s3;
        logic rd_s1;
        logic rd_s2;
        logic rd_s3;
        logic rdy;
        logic err;
        logic [2:0] chan;
        logic [19:0] data;
        arm_ctl_t ctl;
        arm_rdview_t view;
        logic drdy_n;
    } arm_sys_st_t;

    arm_sys_st_t st_r, st_nxt;

    // link-side wires
    arm_lnk_ev_t lnk_ev; // toggles with held payload
    logic lnk_busy; // link inside a frame

    // decoded events
    logic wr_ev; // one write landed
    logic rd_ev; // one read finished
    logic wr_mode; // write aimed at the mode register
    logic opm_pd; // written mode code is power-down

    // the link runs on the host's serial clock
    arm_link u_link (
        .sclk(sclk),
        .nrst(nrst),
        .din(din),
        .dout(dout),
        .rd_view(st_r.view),
        .rdy_lvl(st_r.rdy),
        .ev(lnk_ev),
        .busy(lnk_busy)
    );

    // toggle edges after two-flop synchronisers
    assign wr_ev = st_r.wr_s2 ^ st_r.wr_s3;
    assign rd_ev = st_r.rd_s2 ^ st_r.rd_s3;
    assign wr_mode = wr_ev && (lnk_ev.wr_sel == `ARM_SEL_MODE);
    assign opm_pd = (lnk_ev.wr_word[`ARM_MODE_OPM_HI:`ARM_MODE_OPM_LO] == PWRDN_MODE);

    // outputs straight from flops
    assign ctl = st_r.ctl;
    assign drdy_n = st_r.drdy_n;

    // next state of the register map
    always_comb begin
        st_nxt = st_r;

        // level and toggles from the link domain
        st_nxt.busy_s1 = lnk_busy;
        st_nxt.busy_s2 = st_r.busy_s1;
        st_nxt.wr_s1 = lnk_ev.wr_tgl;
        st_nxt.wr_s2 = st_r.wr_s1;
        st_nxt.wr_s3 = st_r.wr_s2;
        st_nxt.rd_s1 = lnk_ev.rd_tgl;
        st_nxt.rd_s2 = st_r.rd_s1;
        st_nxt.rd_s3 = st_r.rd_s2;

        // strobes last one cycle
        st_nxt.ctl.filter_reset = 1'b0;
        st_nxt.ctl.conv_start = 1'b0;

        // channel under conversion, followed every cycle
        st_nxt.chan = conv.channel;

        // a read of the data marks it stale
        if (rd_ev && (lnk_ev.rd_sel == `ARM_SEL_DATA)) begin
            st_nxt.rdy = 1'b1;
        end

        // warn the host shortly before the data changes
        if (conv.pre_update) begin
            st_nxt.rdy = 1'b1;
        end

        // writes from the link; payload held since its toggle
        if (wr_ev) begin
            unique case (lnk_ev.wr_sel)
                `ARM_SEL_MODE: begin
                    // fixed fields forced to zero
                    st_nxt.ctl.mode = lnk_ev.wr_word[15:0] & `ARM_MODE_KEEP;
                    st_nxt.ctl.filter_reset = 1'b1;
                    if (!opm_pd) begin
                        // any non power-down mode starts converting
                        st_nxt.ctl.conv_start = 1'b1;
                        st_nxt.err = 1'b0;
                    end
                end
                `ARM_SEL_CFG: begin
                    st_nxt.ctl.cfg = lnk_ev.wr_word[15:0];
                end
                `ARM_SEL_IO: begin
                    st_nxt.ctl.io = lnk_ev.wr_word[7:0];
                end
                `ARM_SEL_ZCAL: begin
                    st_nxt.ctl.zcal = lnk_ev.wr_word;
                end
                `ARM_SEL_GCAL: begin
                    st_nxt.ctl.gcal = lnk_ev.wr_word;
                end
                `ARM_SEL_CMD_STAT, `ARM_SEL_DATA, `ARM_SEL_ID: begin
                    // read-only targets ignore writes
                end
            endcase
        end

        // a new result beats a stale mark in the same cycle
        if (conv.done) begin
            st_nxt.data = conv.result;
            st_nxt.rdy = 1'b0;
            st_nxt.err = conv.clamped; // written with ready
        end

        // a mode write discards any result in flight
        if (wr_mode) begin
            st_nxt.rdy = 1'b1;
            if (opm_pd) begin
                st_nxt.rdy = 1'b1; // entering power-down
            end
        end

        // ready mirror for the pin
        st_nxt.drdy_n = st_nxt.rdy;

        // view frozen during a frame so the link reads stable words;
        // the cost is that status seen in a frame is up to one frame old
        if (!st_r.busy_s2) begin
            st_nxt.view.status = {st_r.rdy, st_r.err, `ARM_STAT_ZERO,
                                  `ARM_STAT_ONE, st_r.chan};
            st_nxt.view.mode = st_r.ctl.mode;
            st_nxt.view.cfg = st_r.ctl.cfg;
            st_nxt.view.data = {st_r.data, `ARM_DATA_TAIL};
            st_nxt.view.id = PART_ID;
            st_nxt.view.io = st_r.ctl.io;
            st_nxt.view.zcal = st_r.ctl.zcal;
            st_nxt.view.gcal = st_r.ctl.gcal;
        end
    end

    // registers; reset values are constants only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.rdy <= 1'b1;
            st_r.drdy_n <= 1'b1;
            st_r.ctl.mode <= `ARM_MODE_RST;
            st_r.view.status <= `ARM_STATUS_RST;
            st_r.view.mode <= `ARM_MODE_RST;
            st_r.view.id <= PART_ID;
            st_r.view.data <= {20'h00000, `ARM_DATA_TAIL};
        end else begin
            st_r <= st_nxt;
        end
    end

    // checks on the system side
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // mode write followed by a one-cycle filter reset
    sequence s_mode_wr;
        wr_mode;
    endsequence

    sequence s_filt_pulse;
        ctl.filter_reset && st_r.rdy ##1 !ctl.filter_reset;
    endsequence

    // new result then cleared ready and matching error
    sequence s_result;
        conv.done && !wr_mode;
    endsequence

    AST_STATUS_RESET: assert property (
        $rose(nrst) |-> (st_r.view.status == `ARM_STATUS_RST)
    ) else $error("status view not at reset value");

    AST_MODE_RESET: assert property (
        $rose(nrst) |-> (ctl.mode == `ARM_MODE_RST)
    ) else $error("mode register not at reset value");

    AST_STATUS_FIXED: assert property (
        !st_r.busy_s2 |=> (st_r.view.status[5:3] == 3'h1)
    ) else $error("fixed status bits wrong");

    AST_MODE_ZERO: assert property (
        wr_mode |=> ((ctl.mode & ~`ARM_MODE_KEEP) == 16'h0000)
    ) else $error("fixed mode bits not zero");

    AST_MODE_STORE: assert property (
        wr_mode |=> (ctl.mode == ($past(lnk_ev.wr_word[15:0]) & `ARM_MODE_KEEP))
    ) else $error("mode write not stored");

    AST_FILTER_RESET: assert property (
        s_mode_wr |=> s_filt_pulse
    ) else $error("mode write without filter reset pulse");

    AST_RDY_CLEAR: assert property (
        s_result |=> (!st_r.rdy && !drdy_n)
    ) else $error("ready not cleared by new result");

    AST_ERR_FOLLOWS: assert property (
        s_result |=> (st_r.err == $past(conv.clamped))
    ) else $error("error flag does not follow clamp");

    AST_ERR_CLEAR: assert property (
        (wr_mode && !opm_pd && !conv.done) |=> (!st_r.err && ctl.conv_start)
    ) else $error("start write did not clear error");

    AST_RD_SETS: assert property (
        (rd_ev && (lnk_ev.rd_sel == `ARM_SEL_DATA) && !conv.done) |=> st_r.rdy
    ) else $error("data read did not set ready");

    AST_PRE_SETS: assert property (
        (conv.pre_update && !conv.done) |=> st_r.rdy
    ) else $error("pre-update did not set ready");

    AST_PWRDN_SETS: assert property (
        (wr_mode && opm_pd) |=> (st_r.rdy && drdy_n)
    ) else $error("power-down did not set ready");

    AST_CHAN: assert property (
        ##1 (st_r.chan == $past(conv.channel))
    ) else $error("channel field lags");

    AST_DATA_TAIL: assert property (
        conv.done && !st_r.busy_s2 ##1 !st_r.busy_s2 |=>
            (st_r.view.data == {$past(conv.result, 2), `ARM_DATA_TAIL})
    ) else $error("data view not result plus tail");

    AST_CFG_STORE: assert property (
        (wr_ev && (lnk_ev.wr_sel == `ARM_SEL_CFG)) |=>
            (ctl.cfg == $past(lnk_ev.wr_word[15:0]))
    ) else $error("config write not stored");

    AST_RO_IGNORED: assert property (
        (wr_ev && (lnk_ev.wr_sel == `ARM_SEL_ID)) |=> $stable(ctl)
    ) else $error("write to read-only target changed setup");

    // pin and bit come from one next-state value, so they never part
    AST_DRDY_MIRROR: assert property (
        drdy_n == st_r.rdy
    ) else $error("ready pin differs from ready bit");

    AST_PWRDN_NOSTART: assert property (
        (wr_mode && opm_pd) |=> !ctl.conv_start
    ) else $error("power-down entry started a conversion");

    AST_START_PULSE: assert property (
        ctl.conv_start |=> !ctl.conv_start
    ) else $error("conversion start longer than one cycle");

    AST_FILTER_ONLY_MODE: assert property (
        ctl.filter_reset |-> $past(wr_mode)
    ) else $error("filter reset without a mode write");

    // a frozen view keeps the word under shift intact
    AST_VIEW_FROZEN: assert property (
        st_r.busy_s2 |=> $stable(st_r.view)
    ) else $error("read view changed inside a frame");

    AST_ID_VIEW: assert property (
        !st_r.busy_s2 |=> (st_r.view.id == PART_ID)
    ) else $error("identification view wrong");

    AST_MODE_PRIO: assert property (
        (wr_mode && conv.done) |=> st_r.rdy
    ) else $error("mode write lost ready to a result");

    AST_ERR_DONE_WINS: assert property (
        (wr_mode && !opm_pd && conv.done) |=> (st_r.err == $past(conv.clamped))
    ) else $error("error flag lost to start write");

    AST_MODE_HOLD: assert property (
        !wr_mode |=> $stable(ctl.mode)
    ) else $error("mode changed without a mode write");

    AST_CFG_HOLD: assert property (
        !(wr_ev && (lnk_ev.wr_sel == `ARM_SEL_CFG)) |=> $stable(ctl.cfg)
    ) else $error("config changed without a config write");

    AST_ERR_ONLY_DONE: assert property (
        $rose(st_r.err) |-> $past(conv.done)
    ) else $error("error flag set without a result");

    AST_RDY_FALL_DONE: assert property (
        $fell(st_r.rdy) |-> $past(conv.done)
    ) else $error("ready cleared without a result");

endmodule

// ---- tb/arm_host.sv ----
// host model of the serial link: drives clock and data, samples the read bits
`timescale 1ns/1ps
`include "arm_defs.svh"
module arm_host (
    // serial clock and data toward the device
    output logic sclk,
    output logic din,
    // serial data from the device
    input wire logic dout
);
    // clock stands high between frames, data idles high (ignored while waiting)
    initial begin
        sclk = 1'b1;
        din = 1'b1;
    end

    // one bit: data set while low, device samples on the rising edge
    task automatic bit_out(input logic b);
        sclk = 1'b0;
        din = b;
        #24;
        sclk = 1'b1;
        #24;
    endtask

    // one frame: optional leading ones, command byte, then the data phase
    task automatic xfer(input logic rd, input logic [2:0] sel, input int nbits,
                        input logic [23:0] wdata, input int lead, output logic [23:0] rdata);
        logic [7:0] cmd;
        logic [23:0] wd;
        cmd = {1'b0, rd, sel, 3'h0};
        wd = wdata;
        rdata = 24'h0;
        // fixed mode bits are always sent as zero
        if (!rd && sel == `ARM_SEL_MODE) begin
            wd = wdata & {8'h00, `ARM_MODE_KEEP};
        end
        // leading ones must be skipped by the device
        for (int i = 0; i < lead; i++) begin
            bit_out(1'b1);
        end
        for (int i = 7; i >= 0; i--) begin
            bit_out(cmd[i]);
        end
        // read bits are taken at the falling edge, before the clock drops
        for (int i = nbits - 1; i >= 0; i--) begin
            rdata = {rdata[22:0], dout};
            bit_out(rd ? 1'b1 : wd[i]);
        end
        din = 1'b1;
    endtask
endmodule

// ---- tb/arm_top_test.sv ----
// self-checking bench of the adc register map over its serial link
`timescale 1ns/1ps
`include "arm_defs.svh"
module arm_top_test;
    import arm_pkg::*;
    localparam logic [7:0] TB_ID = 8'h3C; // identification value, arbitrary
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic sclk;
    logic din;
    logic dout;
    logic drdy_n;
    arm_conv_t conv = '0; // conversion core stand-in
    arm_ctl_t ctl;
    int mismatches = 0;
    int n_tests = 0;
    int n_filt = 0; // filter reset pulses seen
    int n_start = 0; // conversion start pulses seen
    int s0;
    int f0;
    logic [23:0] rd;
    logic [2:0] sels [4] = '{`ARM_SEL_CFG, `ARM_SEL_IO, `ARM_SEL_ZCAL, `ARM_SEL_GCAL};
    logic [23:0] vals [4] = '{24'h001234, 24'h0000A5, 24'h123456, 24'hFEDCBA};

    arm_top #(.PWRDN_MODE(3'h3), .PART_ID(TB_ID)) arm_top_i (.clk_sys(clk_sys), .nrst(nrst),
        .sclk(sclk), .din(din), .dout(dout), .conv(conv), .ctl(ctl), .drdy_n(drdy_n));
    arm_host arm_host_i (.sclk(sclk), .din(din), .dout(dout));

    // system clock, 10 ns
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // count the one-cycle strobes toward the conversion core
    always @(posedge clk_sys) begin
        if (ctl.filter_reset === 1'b1) n_filt <= n_filt + 1;
        if (ctl.conv_start === 1'b1) n_start <= n_start + 1;
    end

    // single compare point, unknowns never match
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // report and end the run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // data phase length of each select
    function automatic int len_of(input logic [2:0] sel);
        case (sel)
            `ARM_SEL_MODE, `ARM_SEL_CFG: return 16;
            `ARM_SEL_DATA, `ARM_SEL_ZCAL, `ARM_SEL_GCAL: return 24;
            default: return 8;
        endcase
    endfunction

    // register access; the gap lets the event cross into the system domain
    task automatic reg_read(input logic [2:0] sel, input int lead, output logic [23:0] v);
        arm_host_i.xfer(1'b1, sel, len_of(sel), 24'h0, lead, v);
        #200;
    endtask
    task automatic reg_write(input logic [2:0] sel, input logic [23:0] v);
        logic [23:0] unused;
        arm_host_i.xfer(1'b0, sel, len_of(sel), v, 0, unused);
        #200;
    endtask

    // bounded wait on the ready mirror; a timeout ends the run
    task automatic wait_drdy(input logic lvl);
        int k;
        for (k = 0; k < 60 && drdy_n !== lvl; k++) @(posedge clk_sys);
        check("drdy_n", {23'h0, drdy_n}, {23'h0, lvl});
        if (k == 60) give_verdict();
    endtask

    // one conversion result; result, flag and channel stay as levels
    task automatic conv_done(input logic [19:0] res, input logic clamp, input logic [2:0] ch);
        @(posedge clk_sys);
        #1;
        conv.done = 1'b1;
        conv.result = res;
        conv.clamped = clamp;
        conv.channel = ch;
        @(posedge clk_sys);
        #1;
        conv.done = 1'b0;
    endtask

    // reset for three cycles, released just after an edge
    task automatic do_reset();
        #1;
        nrst = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    initial begin
        do_reset();
        #3; // keeps the link clock out of phase with the system clock
        check("ctl.mode", {8'h0, ctl.mode}, 24'h00000A);
        reg_read(`ARM_SEL_CMD_STAT, 1, rd);
        check("status", rd, 24'h88);
        reg_read(`ARM_SEL_MODE, 0, rd);
        check("mode", rd, 24'h00000A);
        reg_read(`ARM_SEL_ID, 2, rd);
        check("id", rd, {16'h0, TB_ID});
        // identification is read-only
        reg_write(`ARM_SEL_ID, 24'h0000FF);
        // a write with select zero only reloads the command byte
        arm_host_i.xfer(1'b0, `ARM_SEL_CMD_STAT, 0, 24'h0, 0, rd);
        #200;
        reg_read(`ARM_SEL_ID, 0, rd);
        check("id", rd, {16'h0, TB_ID});
        // every read-write setup register except mode, back to back
        foreach (sels[i]) begin
            reg_write(sels[i], vals[i]);
            reg_read(sels[i], 0, rd);
            check("setup", rd, vals[i]);
        end
        check("ctl.cfg", {8'h0, ctl.cfg}, vals[0]);
        check("ctl.io", {16'h0, ctl.io}, vals[1]);
        check("ctl.zcal", ctl.zcal, vals[2]);
        check("ctl.gcal", ctl.gcal, vals[3]);
        // clamped result on channel two
        conv_done(20'hABCDE, 1'b1, 3'h2);
        wait_drdy(1'b0);
        reg_read(`ARM_SEL_CMD_STAT, 0, rd);
        check("status", rd, 24'h4A);
        check("dout idle", {23'h0, dout}, 24'h0);
        reg_read(`ARM_SEL_DATA, 0, rd);
        check("data", rd, 24'hABCDEF);
        wait_drdy(1'b1);
        reg_read(`ARM_SEL_CMD_STAT, 0, rd);
        check("status ready", {23'h0, rd[7]}, 24'h1);
        // mode write starts a conversion: error cleared, ready set, strobes
        conv_done(20'h00000, 1'b1, 3'h5);
        wait_drdy(1'b0);
        s0 = n_start;
        f0 = n_filt;
        reg_write(`ARM_SEL_MODE, 24'h002045);
        wait_drdy(1'b1);
        check("filter_reset", n_filt - f0, 1);
        check("conv_start", n_start - s0, 1);
        check("ctl.mode", {8'h0, ctl.mode}, 24'h002045);
        reg_read(`ARM_SEL_CMD_STAT, 0, rd);
        check("status", rd, 24'h8D);
        reg_read(`ARM_SEL_MODE, 0, rd);
        check("mode", rd, 24'h002045);
        // pre-update window sets ready without a read
        conv_done(20'h12345, 1'b0, 3'h1);
        wait_drdy(1'b0);
        @(posedge clk_sys);
        #1;
        conv.pre_update = 1'b1;
        @(posedge clk_sys);
        #1;
        conv.pre_update = 1'b0;
        wait_drdy(1'b1);
        reg_read(`ARM_SEL_CMD_STAT, 0, rd);
        check("status", rd, 24'h89);
        // power-down entry sets ready and starts nothing
        conv_done(20'h54321, 1'b0, 3'h1);
        wait_drdy(1'b0);
        s0 = n_start;
        reg_write(`ARM_SEL_MODE, 24'h00600A);
        wait_drdy(1'b1);
        check("conv_start", n_start - s0, 0);
        // fixed mode bits never read back as one
        reg_write(`ARM_SEL_MODE, 24'h00FFFF);
        reg_read(`ARM_SEL_MODE, 0, rd);
        check("mode", rd, 24'h00E0CF);
        // second reset in mid-run restores defaults
        conv.channel = 3'h0;
        do_reset();
        reg_read(`ARM_SEL_MODE, 1, rd);
        check("mode", rd, 24'h00000A);
        reg_read(`ARM_SEL_CMD_STAT, 0, rd);
        check("status", rd, 24'h88);
        give_verdict();
    end
endmodule
